// File: design/dual_host_word_mailbox.sv
// dual host word mailbox: main host word port, satellite piece port
`timescale 1ns/1ns
module dual_host_word_mailbox #(
	parameter int WORD_W = mailbox_pkg::MAIN_WIDTH
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                satWide,
	input  wire logic [WORD_W-1:0]   mainDataIn,
	input  wire logic                mainWriteClr,
	input  wire logic                mainWriteSet,
	input  wire logic                mainWordRead,
	input  wire logic                mainStatusRead,
	input  wire logic                mainControlWrite,
	output logic      [WORD_W-1:0]   mainDataOut,
	output logic                     mainHostIrq,
	input  wire logic                satTestOutFull,
	input  wire logic                satTestInEmpty,
	input  wire logic                satRead,
	input  wire logic                satClear,
	input  wire logic                satLoad,
	input  wire logic [17:0]         satDataIn,
	output logic      [17:0]         satDataOut,
	output logic                     satelliteIrq,
	output logic                     skipRequest,
	output logic                     satelliteReadRequest
);
	logic [WORD_W-1:0] outboundBuffer;
	logic [WORD_W-1:0] inboundBuffer;
	logic              outboundFull;
	logic              outboundEmpty;
	logic              inboundFull;
	logic              inboundEmpty;
	logic              satIrqFlag;
	logic [1:0]        readIndex;
	logic              readLast;
	logic [1:0]        loadIndex;
	logic              loadLast;
	logic              wideMeta;
	logic              wideCfg;
	logic [17:0]       next_satData;
	logic [WORD_W-1:0] next_inbound;

	// width strap is a pin: two flops before use, no reset so it survives reset
	always_ff @(posedge core_clk) begin
		wideMeta <= satWide;
		wideCfg  <= wideMeta;
	end

	piece_counter u_readCount (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wide     (wideCfg),
		.restart  (mainWriteSet),
		.step     (satRead),
		.index    (readIndex),
		.last     (readLast)
	);

	piece_counter u_loadCount (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wide     (wideCfg),
		.restart  (satClear),
		.step     (satLoad),
		.index    (loadIndex),
		.last     (loadLast)
	);

	// outbound buffer: clear strobe empties it, set strobe loads the word
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			outboundBuffer <= mailbox_pkg::BUFFER_RESET;
		end else if (mainWriteSet) begin
			outboundBuffer <= mainDataIn;
		end else if (mainWriteClr) begin
			outboundBuffer <= mailbox_pkg::BUFFER_RESET;
		end
	end

	// outbound flags; the last read wins over a stale control clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			outboundFull  <= mailbox_pkg::FLAG_RESET;
			outboundEmpty <= mailbox_pkg::FLAG_RESET;
		end else begin
			if (mainWriteSet) begin
				outboundFull <= 1'b1;
			end else if (satRead && readLast) begin
				outboundFull <= 1'b0;
			end else if (mainControlWrite) begin
				outboundFull <= 1'b0;
			end
			if (satRead && readLast) begin
				outboundEmpty <= 1'b1;
			end else if (mainWriteClr || mainControlWrite) begin
				outboundEmpty <= 1'b0;
			end
		end
	end

	// portion select; 12-bit pieces low first, 18-bit halves low first
	always_comb begin
		next_satData = 18'h00000;
		if (wideCfg) begin
			next_satData = (readIndex == 2'h0) ? outboundBuffer[17:0]
				: outboundBuffer[35:18];
		end else begin
			case (readIndex)
				2'h0:    next_satData = {6'h00, outboundBuffer[11:0]};
				2'h1:    next_satData = {6'h00, outboundBuffer[23:12]};
				2'h2:    next_satData = {6'h00, outboundBuffer[35:24]};
				default: next_satData = 18'h00000;
			endcase
		end
	end

	// satellite data register; holds the last portion read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			satDataOut <= 18'h00000;
		end else if (satRead) begin
			satDataOut <= next_satData;
		end
	end

	// read request follows each read on a wide satellite, one cycle later
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			satelliteReadRequest <= 1'b0;
		end else begin
			satelliteReadRequest <= satRead && wideCfg;
		end
	end

	// skip answers the two flag tests
	assign skipRequest = (satTestOutFull && outboundFull)
		|| (satTestInEmpty && inboundEmpty);

	// merge the incoming piece into the next inbound slot
	always_comb begin
		next_inbound = inboundBuffer;
		if (wideCfg) begin
			if (loadIndex == 2'h0) begin
				next_inbound[17:0] = satDataIn;
			end else begin
				next_inbound[35:18] = satDataIn;
			end
		end else begin
			case (loadIndex)
				2'h0:    next_inbound[11:0]  = satDataIn[11:0];
				2'h1:    next_inbound[23:12] = satDataIn[11:0];
				2'h2:    next_inbound[35:24] = satDataIn[11:0];
				default: next_inbound = inboundBuffer;
			endcase
		end
	end

	// inbound buffer; clear pulse zeroes every bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			inboundBuffer <= mailbox_pkg::BUFFER_RESET;
		end else if (satClear) begin
			inboundBuffer <= mailbox_pkg::BUFFER_RESET;
		end else if (satLoad) begin
			inboundBuffer <= next_inbound;
		end
	end

	// inbound flags; hardware sets win over clears in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			inboundFull  <= mailbox_pkg::FLAG_RESET;
			inboundEmpty <= mailbox_pkg::FLAG_RESET;
		end else begin
			if (satLoad && loadLast) begin
				inboundFull <= 1'b1;
			end else if (mainWordRead || mainControlWrite || satClear) begin
				inboundFull <= 1'b0;
			end
			if (mainWordRead) begin
				inboundEmpty <= 1'b1;
			end else if (satClear || mainControlWrite) begin
				inboundEmpty <= 1'b0;
			end
		end
	end

	// fifth flag: satellite interrupt latched by main word read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			satIrqFlag <= mailbox_pkg::FLAG_RESET;
		end else if (mainWordRead) begin
			satIrqFlag <= 1'b1;
		end else if (satClear || mainControlWrite) begin
			satIrqFlag <= 1'b0;
		end
	end

	// interrupts are plain levels from the flags
	assign satelliteIrq = outboundFull || satIrqFlag;
	assign mainHostIrq  = outboundEmpty || inboundFull;

	// main data register: word or status, held until next read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mainDataOut <= mailbox_pkg::BUFFER_RESET;
		end else if (mainWordRead) begin
			mainDataOut <= inboundBuffer;
		end else if (mainStatusRead) begin
			mainDataOut <= '0;
			mainDataOut[mailbox_pkg::STAT_OUT_EMPTY_BIT] <= outboundEmpty;
			mainDataOut[mailbox_pkg::STAT_OUT_FULL_BIT]  <= outboundFull;
			mainDataOut[mailbox_pkg::STAT_IN_FULL_BIT]   <= inboundFull;
			mainDataOut[mailbox_pkg::STAT_IN_EMPTY_BIT]  <= inboundEmpty;
			mainDataOut[mailbox_pkg::STAT_SAT_IRQ_BIT]   <= satIrqFlag;
		end
	end

	property p_writeLoads;
		@(posedge core_clk) disable iff (!rst_n)
		mainWriteSet |=> (outboundFull && outboundBuffer == $past(mainDataIn));
	endproperty
	a_writeLoads: assert property (p_writeLoads) else $error("word write not loaded");

	property p_satIrq;
		@(posedge core_clk) disable iff (!rst_n)
		mainWriteSet |=> satelliteIrq;
	endproperty
	a_satIrq: assert property (p_satIrq) else $error("satellite irq missing");

	property p_skip;
		@(posedge core_clk) disable iff (!rst_n)
		(satTestOutFull && outboundFull) |-> skipRequest;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not raised");

	property p_readReq;
		@(posedge core_clk) disable iff (!rst_n)
		(satRead && wideCfg) |=> satelliteReadRequest;
	endproperty
	a_readReq: assert property (p_readReq) else $error("read request missing");

	property p_lastRead;
		@(posedge core_clk) disable iff (!rst_n)
		(satRead && readLast && !mainWriteSet) |=> (outboundEmpty && !outboundFull);
	endproperty
	a_lastRead: assert property (p_lastRead) else $error("last read flags wrong");

	property p_mainIrq;
		@(posedge core_clk) disable iff (!rst_n)
		(satRead && readLast && !mainWriteSet) |=> mainHostIrq;
	endproperty
	a_mainIrq: assert property (p_mainIrq) else $error("main irq missing");

	property p_status28;
		@(posedge core_clk) disable iff (!rst_n)
		(mainStatusRead && !mainWordRead)
			|=> mainDataOut[mailbox_pkg::STAT_OUT_EMPTY_BIT] == $past(outboundEmpty);
	endproperty
	a_status28: assert property (p_status28) else $error("status bit wrong");

	property p_control;
		@(posedge core_clk) disable iff (!rst_n)
		(mainControlWrite && !satRead && !satLoad && !mainWordRead && !mainWriteSet)
			|=> !mainHostIrq;
	endproperty
	a_control: assert property (p_control) else $error("control clear failed");

	property p_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(satClear && !mainWordRead) |=> (inboundBuffer == '0 && !inboundEmpty);
	endproperty
	a_clear: assert property (p_clear) else $error("inbound clear failed");

	property p_wordRead;
		@(posedge core_clk) disable iff (!rst_n)
		(mainWordRead && !(satLoad && loadLast)) |=>
			(mainDataOut == $past(inboundBuffer) && inboundEmpty && !inboundFull
			&& satelliteIrq);
	endproperty
	a_wordRead: assert property (p_wordRead) else $error("word read failed");

	// clear strobe of a word write empties the buffer and drops the empty flag
	property p_clearStrobe;
		@(posedge core_clk) disable iff (!rst_n)
		(mainWriteClr && !mainWriteSet && !(satRead && readLast))
			|=> (outboundBuffer == '0 && !outboundEmpty);
	endproperty
	a_clearStrobe: assert property (p_clearStrobe) else $error("clear strobe failed");

	property p_loadFull;
		@(posedge core_clk) disable iff (!rst_n)
		(satLoad && loadLast) |=> (inboundFull && mainHostIrq);
	endproperty
	a_loadFull: assert property (p_loadFull) else $error("inbound full not set");

	property p_firstPiece;
		@(posedge core_clk) disable iff (!rst_n)
		(satRead && !wideCfg && readIndex == 2'h0)
			|=> satDataOut == {6'h00, $past(outboundBuffer[11:0])};
	endproperty
	a_firstPiece: assert property (p_firstPiece) else $error("first piece wrong");

	property p_secondLoad;
		@(posedge core_clk) disable iff (!rst_n)
		(satLoad && !satClear && wideCfg && loadIndex == 2'h1)
			|=> inboundBuffer[35:18] == $past(satDataIn);
	endproperty
	a_secondLoad: assert property (p_secondLoad) else $error("upper half not loaded");

	property p_readReqPulse;
		@(posedge core_clk) disable iff (!rst_n)
		!(satRead && wideCfg) |=> !satelliteReadRequest;
	endproperty
	a_readReqPulse: assert property (p_readReqPulse) else $error("read request stuck");

	property p_statusIn;
		@(posedge core_clk) disable iff (!rst_n)
		(mainStatusRead && !mainWordRead)
			|=> mainDataOut[mailbox_pkg::STAT_IN_FULL_BIT] == $past(inboundFull);
	endproperty
	a_statusIn: assert property (p_statusIn) else $error("inbound full status wrong");
endmodule // dual_host_word_mailbox

// File: design/piece_counter.sv
// counts satellite transfer pieces and flags the final one
`timescale 1ns/1ns
module piece_counter (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       wide,
	input  wire logic       restart,
	input  wire logic       step,
	output logic      [1:0] index,
	output logic            last
);
	// last piece depends on satellite width
	assign last = wide ? (index == 2'h1) : (index == 2'h2);

	// restart wins, the final step wraps to zero
	always_ff @(posedge core_clk) begin
		if (!rst_n || restart) begin
			index <= 2'h0;
		end else if (step) begin
			index <= last ? 2'h0 : index + 2'h1;
		end
	end
endmodule // piece_counter

// File: inc/mailbox_pkg.sv
// shared constants for the dual host word mailbox
package mailbox_pkg;
	localparam int MAIN_WIDTH = 36;
	localparam int SAT_WIDTH  = 18;
	localparam int PORTION12  = 12;
	localparam int PORTION18  = 18;
	localparam int PIECES12   = 3;
	localparam int PIECES18   = 2;
	// status word bit positions
	localparam int STAT_OUT_EMPTY_BIT = 28;
	localparam int STAT_OUT_FULL_BIT  = 29;
	localparam int STAT_IN_FULL_BIT   = 30;
	localparam int STAT_IN_EMPTY_BIT  = 31;
	localparam int STAT_SAT_IRQ_BIT   = 32;
	// reset values
	localparam logic [35:0] BUFFER_RESET = 36'h000000000;
	localparam logic        FLAG_RESET   = 1'b0;
	// clear strobe to set strobe spacing of a main word write
	localparam int WRITE_GAP_NS  = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_GAP_CYC = WRITE_GAP_NS / CLK_PERIOD_NS;
endpackage

// File: tb/dual_host_word_mailbox_bench.sv
// self-checking bench for the dual host word mailbox
`timescale 1ns/1ns
module dual_host_word_mailbox_bench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        satWide = 1'b0;
	logic [35:0] mainDataIn = '0;
	logic [4:0]  mstb = '0;
	logic [1:0]  tst = '0;
	logic [35:0] mainDataOut;
	logic [17:0] satDataOut;
	logic [17:0] satDataIn;
	logic        mainHostIrq;
	logic        satelliteIrq;
	logic        skipRequest;
	logic        satelliteReadRequest;
	logic        satRead;
	logic        satClear;
	logic        satLoad;
	logic [35:0] irqs;
	logic [35:0] w;
	logic [35:0] got;
	int          reqs;
	int          failures = 0;
	int          tests_run = 0;

	assign irqs = {34'h0, mainHostIrq, satelliteIrq};
	always #5 core_clk = ~core_clk;

	// main strobes: 0 clr, 1 set, 2 word read, 3 status read, 4 control write
	dual_host_word_mailbox u_dut (.core_clk(core_clk), .rst_n(rst_n), .satWide(satWide),
		.mainDataIn(mainDataIn), .mainWriteClr(mstb[0]), .mainWriteSet(mstb[1]),
		.mainWordRead(mstb[2]), .mainStatusRead(mstb[3]), .mainControlWrite(mstb[4]),
		.mainDataOut(mainDataOut), .mainHostIrq(mainHostIrq), .satTestOutFull(tst[0]),
		.satTestInEmpty(tst[1]), .satRead(satRead), .satClear(satClear), .satLoad(satLoad),
		.satDataIn(satDataIn), .satDataOut(satDataOut), .satelliteIrq(satelliteIrq),
		.skipRequest(skipRequest), .satelliteReadRequest(satelliteReadRequest));

	satellite_host_model u_sat (.core_clk(core_clk), .satWide(satWide),
		.satDataOut(satDataOut), .satelliteReadRequest(satelliteReadRequest),
		.satRead(satRead), .satClear(satClear), .satLoad(satLoad), .satDataIn(satDataIn));

	// expected status word: flags sit in bits 32 down to 28
	function automatic logic [35:0] stat(logic oe, logic of, logic inf, logic ie, logic si);
		stat = {3'h0, si, ie, inf, of, oe, 28'h0};
	endfunction

	task automatic check(string what, logic [35:0] exp, logic [35:0] seen);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic strobe(int k);
		@(posedge core_clk);
		#1 mstb[k] = 1'b1;
		@(posedge core_clk);
		#1 mstb = '0;
	endtask

	task automatic status(logic [35:0] exp);
		strobe(3);
		check("status", exp, mainDataOut);
	endtask

	// clear strobe, set strobe exactly the gap later; data lines then inverted
	task automatic write(logic [35:0] word);
		strobe(0);
		mainDataIn = word;
		repeat (mailbox_pkg::WRITE_GAP_CYC - 2) @(posedge core_clk);
		strobe(1);
		mainDataIn = ~word;
	endtask

	// skip is combinational, looked at in the cycle of the test
	task automatic skip(int k, logic exp);
		@(posedge core_clk);
		#1 tst[k] = 1'b1;
		#1 check("skip", {35'h0, exp}, {35'h0, skipRequest});
		@(posedge core_clk);
		#1 tst = '0;
	endtask

	// second edge after release is the first legal request
	task automatic reset(logic wide);
		rst_n = 1'b0;
		satWide = wide;
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		@(posedge core_clk);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// the whole run is well under two thousand cycles
	initial begin
		#200000;
		failures++;
		end_sim();
	end

	// mode 0 is the 12-bit satellite, mode 1 the 18-bit one
	initial begin
		void'($urandom(32'ha1e1));
		for (int m = 0; m < 2; m++) begin
			reset(m[0]);
			status(36'h0);
			check("irqs", 36'h0, irqs);
			w = m[0] ? 36'h800000001 : {4'($urandom), $urandom};
			write(w);
			check("satellite irq", 36'h1, irqs);
			status(stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
			skip(0, 1'b1);
			u_sat.unload(got, reqs);
			check("outbound word", w, got);
			check("read requests", m[0] ? 36'h2 : 36'h0, 36'(reqs));
			status(stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
			check("irqs", 36'h2, irqs);
			skip(0, 1'b0);
			strobe(0);
			check("irqs", 36'h0, irqs);
			strobe(4);
			status(36'h0);
			check("irqs", 36'h0, irqs);
			// second pass reloads after finding inbound empty
			for (int k = 0; k < 2; k++) begin
				w = k ? ~w : {4'($urandom), $urandom};
				u_sat.load(w);
				status(stat(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
				check("irqs", 36'h2, irqs);
				strobe(2);
				check("inbound word", w, mainDataOut);
				status(stat(1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
				check("irqs", 36'h1, irqs);
				skip(1, 1'b1);
			end
			strobe(4);
			status(36'h0);
			check("irqs", 36'h0, irqs);
			$display("test %0d done", m);
		end
		end_sim();
	end
endmodule // dual_host_word_mailbox_bench

// File: tb/satellite_host_model.sv
// satellite host model: clears, loads and unloads the mailbox in pieces
`timescale 1ns/1ns
module satellite_host_model (
	input  wire logic        core_clk,
	input  wire logic        satWide,
	input  wire logic [17:0] satDataOut,
	input  wire logic        satelliteReadRequest,
	output logic             satRead,
	output logic             satClear,
	output logic             satLoad,
	output logic      [17:0] satDataIn
);
	// idle strobes, data lines parked on a pattern
	initial begin
		satRead = 1'b0;
		satClear = 1'b0;
		satLoad = 1'b0;
		satDataIn = 18'h2aaaa;
	end

	// random pause so the host is sometimes prompt, sometimes slow
	task automatic pause();
		repeat ($urandom_range(3)) @(posedge core_clk);
		@(posedge core_clk);
		#1;
	endtask

	// unload low piece first, counting read requests seen
	task automatic unload(output logic [35:0] word, output int reqs);
		int n;
		n = satWide ? 2 : 3;
		word = '0;
		reqs = 0;
		for (int i = 0; i < n; i++) begin
			pause();
			satRead = 1'b1;
			@(posedge core_clk);
			#1 satRead = 1'b0;
			reqs += int'(satelliteReadRequest);
			if (satWide)
				word[18*i +: 18] = satDataOut;
			else
				word[12*i +: 12] = satDataOut[11:0];
		end
	endtask

	// clear first, then one piece a load; lines inverted once released
	task automatic load(input logic [35:0] word);
		int n;
		n = satWide ? 2 : 3;
		pause();
		satClear = 1'b1;
		@(posedge core_clk);
		#1 satClear = 1'b0;
		for (int i = 0; i < n; i++) begin
			pause();
			satDataIn = satWide ? word[18*i +: 18] : {6'h2a, word[12*i +: 12]};
			satLoad = 1'b1;
			@(posedge core_clk);
			#1 satLoad = 1'b0;
			satDataIn = ~satDataIn;
		end
	endtask
endmodule // satellite_host_model
